// [src/pdref_pkg.sv]
// shared constants and types for the parallel speed reference decoder
package pdref_pkg;

	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  OFF_CONFIG     = 4'h0;
	localparam logic [3:0]  OFF_STATUS     = 4'h4;
	localparam logic [3:0]  OFF_RAW        = 4'h8;
	localparam logic [3:0]  OFF_VALUE      = 4'hc;

	// config register field positions
	localparam int          CFG_FMT_LSB    = 0;
	localparam int          CFG_WIDTH_BIT  = 3;
	localparam int          CFG_BOARD8_BIT = 4;
	localparam logic [4:0]  CFG_RESET      = 5'h00;

	// status register field positions
	localparam int          ST_VALID_BIT   = 0;
	localparam int          ST_FMTERR_BIT  = 1;
	localparam int          ST_DIGERR_BIT  = 2;
	localparam int          ST_REV_BIT     = 3;
	localparam int          ST_FULL_BIT    = 4;
	localparam int          ST_UNIT_LSB    = 5;
	localparam int          ST_DEC_LSB     = 7;

	// raw register field positions
	localparam int          RAW_HIGH_LSB   = 12;
	localparam int          RAW_SIGN_BIT   = 16;

	// reference format settings
	localparam logic [2:0]  FMT_BCD_LAST   = 3'h5;
	localparam logic [2:0]  FMT_BCD5       = 3'h6;
	localparam logic [2:0]  FMT_BINARY     = 3'h7;
	localparam logic [2:0]  FMT_HZ_FIRST   = 3'h3;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {
		UNIT_PERCENT = 2'h0,
		UNIT_HZ      = 2'h1,
		UNIT_BINARY  = 2'h2,
		UNIT_HZ_BCD5 = 2'h3
	} pdref_unit_t;

	typedef struct packed {
		logic [2:0] fmt;
		logic       width16;
		logic       board8;
	} pdref_cfg_t;

	typedef struct packed {
		logic        sign;
		logic [3:0]  high;
		logic [11:0] low;
	} pdref_word_t;

	typedef struct packed {
		logic        fmt_err;
		logic        digit_err;
		logic        full_scale;
		logic        reverse;
		pdref_unit_t unit;
		logic [1:0]  decimals;
		logic [15:0] mag;
	} pdref_ref_t;

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} pdref_wr_state_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} pdref_rd_state_t;

endpackage : pdref_pkg

// [src/pdref_sync.sv]
// two-stage synchroniser for the terminal inputs
`timescale 1ns/1ps
`default_nettype none
module pdref_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule : pdref_sync
`default_nettype wire

// [src/pdref_decoder.sv]
// parallel speed reference decoder with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] decoding depends on format setting and the 12/16-bit width switch together
// [R2] format 7, 12 bit: magnitude bits 0..11 on low terminals, sign 0 forward
// [R3] format 7, 16 bit: high terminals add bits 12..15, signed magnitude
// [R4] formats 0..5, 12 bit: three BCD digits, four inputs each, LSD first
// [R5] formats 0..5, 16 bit: fourth BCD digit on the high terminals
// [R6] format 6: five unsigned digits, lowest weights 2/4/8, top uses sign
// [R7] format 6 treats sign as data, only positive values, 0.02 Hz steps
// [R8] format 6 only accepted with the 16-bit board
// [R9] binary formats: all magnitude inputs high means full scale
// [R10] controller raises the read strobe to request a word capture
// [R11] 8-bit board, format 7: magnitude bits 0..7, then sign and strobe
// [R12] 8-bit board, formats 0..5: low digit 0..9, high digit 0..15
// [R13] 8-bit board refuses to operate under format 6
// [R14] formats 0..2 percent units, 3..5 hertz units, 7 binary
// [R15] inputs captured while strobe is high, held while it is low
module pdref_decoder (
	input  wire logic                  CLK_I,
	input  wire logic                  RESET_I,
	input  wire logic [11:0]           LOW_TERMINAL_BLOCK_I,
	input  wire logic [3:0]            HIGH_TERMINAL_BLOCK_I,
	input  wire logic                  SIGN_I,
	input  wire logic                  READ_STROBE_I,
	input  wire logic [3:0]            S_AXI_AWADDR_I,
	input  wire logic                  S_AXI_AWVALID_I,
	output var  logic                  S_AXI_AWREADY_O,
	input  wire logic [31:0]           S_AXI_WDATA_I,
	input  wire logic [3:0]            S_AXI_WSTRB_I,
	input  wire logic                  S_AXI_WVALID_I,
	output var  logic                  S_AXI_WREADY_O,
	output var  logic [1:0]            S_AXI_BRESP_O,
	output var  logic                  S_AXI_BVALID_O,
	input  wire logic                  S_AXI_BREADY_I,
	input  wire logic [3:0]            S_AXI_ARADDR_I,
	input  wire logic                  S_AXI_ARVALID_I,
	output var  logic                  S_AXI_ARREADY_O,
	output var  logic [31:0]           S_AXI_RDATA_O,
	output var  logic [1:0]            S_AXI_RRESP_O,
	output var  logic                  S_AXI_RVALID_O,
	input  wire logic                  S_AXI_RREADY_I,
	output var  logic [15:0]           REF_MAG_O,
	output var  logic                  REF_REVERSE_O,
	output var  logic                  REF_FULL_SCALE_O,
	output var  logic                  REF_VALID_O,
	output var  logic                  REF_LOADED_O
);
	import pdref_pkg::*;

	function automatic logic [15:0] bcd_value(input logic [3:0] d1, input logic [3:0] d2,
			input logic [3:0] d3, input logic [3:0] d4, input logic [3:0] d5);
		logic [16:0] sum;
		sum = 17'(d1) + 17'(d2) * 17'd10 + 17'(d3) * 17'd100 + 17'(d4) * 17'd1000
			+ 17'(d5) * 17'd10000;
		return sum[15:0];
	endfunction : bcd_value

	function automatic logic over_nine(input logic [3:0] d);
		return d > 4'h9;
	endfunction : over_nine

	// terminal pins synchronised as one word; a controller changing data and
	// strobe together may see a mixed word for one cycle, so it should settle
	// data before raising the strobe
	pdref_word_t pins_sync;
	logic        strobe_sync;

	pdref_sync #(
		.W ($bits(pdref_word_t) + 1)
	) u_sync (
		.clk_i   (CLK_I),
		.reset_i (RESET_I),
		.async_i ({SIGN_I, HIGH_TERMINAL_BLOCK_I, LOW_TERMINAL_BLOCK_I, READ_STROBE_I}),
		.sync_o  ({pins_sync, strobe_sync})
	);

	// capture of the reference word
	pdref_word_t held;
	pdref_word_t next_held;
	logic        loaded;
	logic        next_loaded;
	logic        have_word;
	logic        next_have_word;

	always_comb begin
		next_held      = held;
		next_loaded    = 1'b0;
		next_have_word = have_word;
		if (strobe_sync) begin // R10
			next_held      = pins_sync; // R15
			next_loaded    = 1'b1;
			next_have_word = 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			held      <= '0;
			loaded    <= 1'b0;
			have_word <= 1'b0;
		end else begin
			held      <= next_held;
			loaded    <= next_loaded;
			have_word <= next_have_word;
		end
	end

	// decode of the held word under the current configuration
	pdref_cfg_t cfg;
	pdref_ref_t dec;

	always_comb begin
		dec          = '0;
		dec.reverse  = held.sign;
		dec.decimals = 2'(cfg.fmt % 3'h3); // R14
		if (cfg.fmt == FMT_BINARY) begin
			dec.unit = UNIT_BINARY; // R14
		end else if (cfg.fmt == FMT_BCD5) begin
			dec.unit = UNIT_HZ_BCD5;
		end else if (cfg.fmt >= FMT_HZ_FIRST) begin
			dec.unit = UNIT_HZ;
		end else begin
			dec.unit = UNIT_PERCENT;
		end
		if (cfg.board8) begin
			if (cfg.fmt == FMT_BINARY) begin
				dec.mag        = {8'h00, held.low[7:0]}; // R11
				dec.full_scale = &held.low[7:0]; // R9
			end else if (cfg.fmt <= FMT_BCD_LAST) begin
				dec.mag       = bcd_value(held.low[3:0], held.low[7:4], 4'h0, 4'h0, 4'h0); // R12
				dec.digit_err = over_nine(held.low[3:0]);
			end else begin
				dec.fmt_err = 1'b1; // R13
				dec.reverse = 1'b0;
			end
		end else begin
			case (cfg.fmt) // R1
			FMT_BINARY: begin
				if (cfg.width16) begin
					dec.mag        = {held.high, held.low}; // R3
					dec.full_scale = &{held.high, held.low}; // R9
				end else begin
					dec.mag        = {4'h0, held.low}; // R2
					dec.full_scale = &held.low; // R9
				end
			end
			FMT_BCD5: begin
				dec.reverse = 1'b0; // R7
				if (cfg.width16) begin
					dec.mag = bcd_value({held.low[2:0], 1'b0}, held.low[6:3], held.low[10:7],
						{held.high[2:0], held.low[11]}, {2'b00, held.sign, held.high[3]}); // R6
					dec.digit_err = over_nine({held.low[2:0], 1'b0}) | over_nine(held.low[6:3])
						| over_nine(held.low[10:7]) | over_nine({held.high[2:0], held.low[11]});
				end else begin
					dec.fmt_err = 1'b1; // R8
				end
			end
			default: begin
				if (cfg.width16) begin
					dec.mag = bcd_value(held.low[3:0], held.low[7:4], held.low[11:8],
						held.high, 4'h0); // R5
					dec.digit_err = over_nine(held.low[3:0]) | over_nine(held.low[7:4])
						| over_nine(held.low[11:8]) | over_nine(held.high);
				end else begin
					dec.mag = bcd_value(held.low[3:0], held.low[7:4], held.low[11:8],
						4'h0, 4'h0); // R4
					dec.digit_err = over_nine(held.low[3:0]) | over_nine(held.low[7:4])
						| over_nine(held.low[11:8]);
				end
			end
			endcase
		end
	end

	// registered reference outputs
	pdref_ref_t refq;
	pdref_ref_t next_refq;
	logic       next_valid;
	logic       valid_q;

	always_comb begin
		next_refq  = dec;
		next_valid = have_word;
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			refq             <= '0;
			valid_q          <= 1'b0;
			REF_MAG_O        <= '0;
			REF_REVERSE_O    <= 1'b0;
			REF_FULL_SCALE_O <= 1'b0;
			REF_VALID_O      <= 1'b0;
			REF_LOADED_O     <= 1'b0;
		end else begin
			refq             <= next_refq;
			valid_q          <= next_valid;
			REF_MAG_O        <= next_refq.fmt_err ? 16'h0000 : next_refq.mag;
			REF_REVERSE_O    <= next_refq.reverse & ~next_refq.fmt_err;
			REF_FULL_SCALE_O <= next_refq.full_scale;
			REF_VALID_O      <= next_valid & ~next_refq.fmt_err & ~next_refq.digit_err;
			REF_LOADED_O     <= loaded;
		end
	end

	// AXI4-Lite write channel
	pdref_wr_state_t wr_state;
	pdref_wr_state_t next_wr_state;
	logic            aw_got;
	logic            next_aw_got;
	logic            w_got;
	logic            next_w_got;
	logic [3:0]      awaddr;
	logic [3:0]      next_awaddr;
	logic [31:0]     wdata;
	logic [31:0]     next_wdata;
	logic [3:0]      wstrb;
	logic [3:0]      next_wstrb;
	logic [1:0]      next_bresp;
	pdref_cfg_t      next_cfg;

	always_comb begin
		next_wr_state = wr_state;
		next_aw_got   = aw_got;
		next_w_got    = w_got;
		next_awaddr   = awaddr;
		next_wdata    = wdata;
		next_wstrb    = wstrb;
		next_bresp    = S_AXI_BRESP_O;
		next_cfg      = cfg;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			next_aw_got = 1'b1;
			next_awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			next_w_got = 1'b1;
			next_wdata = S_AXI_WDATA_I;
			next_wstrb = S_AXI_WSTRB_I;
		end
		case (wr_state)
		WR_IDLE: begin
			if (next_aw_got && next_w_got) begin
				next_aw_got   = 1'b0;
				next_w_got    = 1'b0;
				next_wr_state = WR_RESP;
				next_bresp    = RESP_OKAY;
				case ({next_awaddr[3:2], 2'b00})
				OFF_CONFIG: begin
					if (next_wstrb[0]) begin
						next_cfg.fmt     = next_wdata[CFG_FMT_LSB +: 3];
						next_cfg.width16 = next_wdata[CFG_WIDTH_BIT];
						next_cfg.board8  = next_wdata[CFG_BOARD8_BIT];
					end
				end
				OFF_STATUS, OFF_RAW, OFF_VALUE: begin
					next_bresp = RESP_OKAY;
				end
				default: begin
					next_bresp = RESP_SLVERR;
				end
				endcase
			end
		end
		WR_RESP: begin
			if (S_AXI_BREADY_I) begin
				next_wr_state = WR_IDLE;
			end
		end
		default: begin
			next_wr_state = WR_IDLE;
		end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			wr_state        <= WR_IDLE;
			aw_got          <= 1'b0;
			w_got           <= 1'b0;
			awaddr          <= '0;
			wdata           <= '0;
			wstrb           <= '0;
			cfg             <= CFG_RESET;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= RESP_OKAY;
		end else begin
			wr_state        <= next_wr_state;
			aw_got          <= next_aw_got;
			w_got           <= next_w_got;
			awaddr          <= next_awaddr;
			wdata           <= next_wdata;
			wstrb           <= next_wstrb;
			cfg             <= next_cfg;
			S_AXI_AWREADY_O <= ~next_aw_got && next_wr_state == WR_IDLE;
			S_AXI_WREADY_O  <= ~next_w_got && next_wr_state == WR_IDLE;
			S_AXI_BVALID_O  <= next_wr_state == WR_RESP;
			S_AXI_BRESP_O   <= next_bresp;
		end
	end

	// AXI4-Lite read channel
	pdref_rd_state_t rd_state;
	pdref_rd_state_t next_rd_state;
	logic [31:0]     next_rdata;
	logic [1:0]      next_rresp;
	logic [31:0]     status_word;

	always_comb begin
		status_word                          = '0;
		status_word[ST_VALID_BIT]            = valid_q;
		status_word[ST_FMTERR_BIT]           = refq.fmt_err;
		status_word[ST_DIGERR_BIT]           = refq.digit_err;
		status_word[ST_REV_BIT]              = refq.reverse;
		status_word[ST_FULL_BIT]             = refq.full_scale;
		status_word[ST_UNIT_LSB +: 2]        = refq.unit;
		status_word[ST_DEC_LSB +: 2]         = refq.decimals;
		next_rd_state = rd_state;
		next_rdata    = S_AXI_RDATA_O;
		next_rresp    = S_AXI_RRESP_O;
		case (rd_state)
		RD_IDLE: begin
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
				next_rd_state = RD_DATA;
				next_rresp    = RESP_OKAY;
				next_rdata    = '0;
				case ({S_AXI_ARADDR_I[3:2], 2'b00})
				OFF_CONFIG: begin
					next_rdata[CFG_FMT_LSB +: 3] = cfg.fmt;
					next_rdata[CFG_WIDTH_BIT]    = cfg.width16;
					next_rdata[CFG_BOARD8_BIT]   = cfg.board8;
				end
				OFF_STATUS: next_rdata = status_word;
				OFF_RAW: begin
					next_rdata[RAW_HIGH_LSB - 1:0]       = held.low;
					next_rdata[RAW_HIGH_LSB +: 4]        = held.high;
					next_rdata[RAW_SIGN_BIT]             = held.sign;
				end
				OFF_VALUE: next_rdata[15:0] = refq.mag;
				default: next_rresp = RESP_SLVERR;
				endcase
			end
		end
		RD_DATA: begin
			if (S_AXI_RREADY_I) begin
				next_rd_state = RD_IDLE;
			end
		end
		default: begin
			next_rd_state = RD_IDLE;
		end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rd_state        <= RD_IDLE;
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= RESP_OKAY;
		end else begin
			rd_state        <= next_rd_state;
			S_AXI_ARREADY_O <= next_rd_state == RD_IDLE;
			S_AXI_RVALID_O  <= next_rd_state == RD_DATA;
			S_AXI_RDATA_O   <= next_rdata;
			S_AXI_RRESP_O   <= next_rresp;
		end
	end
endmodule : pdref_decoder
`default_nettype wire

// [dv/pdref_decoder_checker.sv]
// port assertions for the reference decoder
`timescale 1ns/1ps
`default_nettype none
module pdref_decoder_checker (
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic        READ_STROBE_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic [15:0] REF_MAG_O,
	input wire logic        REF_FULL_SCALE_O,
	input wire logic        REF_LOADED_O
);
	import pdref_pkg::*;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	sequence s_wr_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	// two synchroniser stages, the loaded register and the REF_LOADED_O output register
	sequence s_loaded;
		##[3:4] REF_LOADED_O;
	endsequence
	a_ready_after_reset: assert property ($fell(RESET_I) |=> S_AXI_AWREADY_O && S_AXI_ARREADY_O)
		else $error("ready low after reset");
	a_write_answer: assert property (s_wr_taken |=> S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_OKAY)
		else $error("no write response");
	a_write_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write taken while busy");
	a_write_release: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
		|=> !S_AXI_BVALID_O && S_AXI_AWREADY_O) else $error("write response stuck");
	a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
		|=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("no read data");
	a_read_release: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I
		|=> !S_AXI_RVALID_O && S_AXI_ARREADY_O) else $error("read data stuck");
	a_capture_time: assert property (READ_STROBE_I |-> s_loaded)
		else $error("strobe not captured");
	a_no_spurious: assert property (REF_LOADED_O |-> $past(READ_STROBE_I, 3) || $past(READ_STROBE_I, 4))
		else $error("load without strobe");
	a_full_scale_mag: assert property (REF_FULL_SCALE_O |-> REF_MAG_O inside {16'h00ff, 16'h0fff, 16'hffff})
		else $error("full scale with partial magnitude");
endmodule : pdref_decoder_checker
bind pdref_decoder pdref_decoder_checker pdref_decoder_checker_inst (.CLK_I, .RESET_I,
	.READ_STROBE_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
	.S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
	.S_AXI_RVALID_O, .S_AXI_RREADY_I, .REF_MAG_O, .REF_FULL_SCALE_O, .REF_LOADED_O);
`default_nettype wire

// [dv/pdref_ctrl_model.sv]
// controller model presenting reference words on the terminal pins
`timescale 1ns/1ps
`default_nettype none
module pdref_ctrl_model (
	input  wire logic                   clk_i,
	input  wire logic                   send_i,
	input  wire logic                   slow_i,
	input  wire pdref_pkg::pdref_word_t word_i,
	output var  pdref_pkg::pdref_word_t pins_o,
	output var  logic                   strobe_o,
	output var  logic                   busy_o
);
	import pdref_pkg::*;
	initial pins_o = '0;
	initial strobe_o = 1'b0;
	initial busy_o = 1'b0;
	// data leads the strobe since each pin is synchronised on its own
	always @(posedge clk_i) begin
		if (send_i && !busy_o) begin
			busy_o <= 1'b1;
			pins_o <= word_i;
			repeat (slow_i ? 6 : 2) @(posedge clk_i);
			strobe_o <= 1'b1;
			@(posedge clk_i);
			strobe_o <= 1'b0;
			repeat (3) @(posedge clk_i);
			// lines keep moving after the read, the held word must not follow
			pins_o <= ~word_i;
			busy_o <= 1'b0;
		end
	end
endmodule : pdref_ctrl_model
`default_nettype wire

// [dv/pdref_decoder_bench.sv]
// self-checking bench for the parallel speed reference decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module pdref_decoder_bench;
	import pdref_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, send = 1'b0, slow = 1'b0;
	logic [3:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rnd = 32'he699;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, rev, full, valid, loaded, strobe, busy;
	logic [1:0]  bresp, rresp;
	logic [15:0] mag;
	pdref_word_t word = '0, pins, w;
	pdref_cfg_t  cfg = '0;
	logic [18:0] last_e, ref_e, ref_q [$];
	logic [63:0] rd_e, rd_q [$];
	int          num_errors = 0, num_checks = 0;
	pdref_decoder pdref_decoder_inst (.CLK_I(clk), .RESET_I(rst),
		.LOW_TERMINAL_BLOCK_I(pins.low), .HIGH_TERMINAL_BLOCK_I(pins.high),
		.SIGN_I(pins.sign), .READ_STROBE_I(strobe), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .REF_MAG_O(mag), .REF_REVERSE_O(rev),
		.REF_FULL_SCALE_O(full), .REF_VALID_O(valid), .REF_LOADED_O(loaded));
	pdref_ctrl_model pdref_ctrl_model_inst (.clk_i(clk), .send_i(send), .slow_i(slow),
		.word_i(word), .pins_o(pins), .strobe_o(strobe), .busy_o(busy));
	initial forever #4 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// random word with digits kept legal for the chosen format
	function automatic pdref_word_t mkword(input pdref_cfg_t c, input logic [31:0] r);
		logic [3:0] d [4];
		for (int i = 0; i < 4; i++) d[i] = r[4*i+:4] % 4'ha;
		if (c.fmt == FMT_BINARY) return r[16:0];
		if (c.fmt == FMT_BCD5) return {r[21:20], d[3], d[2], d[1], (r[1:0] == 2'h3) ? 3'h4 : {1'b0, r[1:0]}};
		if (c.board8) d[1] = r[7:4];
		return {r[16], d[3], d[2], d[1], d[0]};
	endfunction : mkword
	// packed as valid, full scale, reverse, magnitude
	function automatic logic [18:0] expect_ref(input pdref_cfg_t c, input pdref_word_t x);
		logic [15:0] m;
		logic        v;
		if (c.fmt == FMT_BCD5) begin
			if (c.board8 || !c.width16) return '0;
			m = {x.low[2:0], 1'b0} + x.low[6:3] * 16'd10 + x.low[10:7] * 16'd100
				+ {x.high[2:0], x.low[11]} * 16'd1000 + {x.sign, x.high[3]} * 16'd10000;
			return {1'b1, 2'b00, m};
		end
		if (c.fmt == FMT_BINARY) begin
			m = c.board8 ? {8'h0, x.low[7:0]} : c.width16 ? {x.high, x.low} : {4'h0, x.low};
			return {1'b1, m == (c.board8 ? 16'hff : c.width16 ? 16'hffff : 16'hfff), x.sign, m};
		end
		m = x.low[3:0] + x.low[7:4] * 16'd10;
		if (!c.board8) m = m + x.low[11:8] * 16'd100 + (c.width16 ? x.high * 16'd1000 : 16'd0);
		// a digit above nine leaves the magnitude in place but drops valid
		v = x.low[3:0] < 4'ha;
		if (!c.board8)
			v = v && x.low[7:4] < 4'ha && x.low[11:8] < 4'ha && (!c.width16 || x.high < 4'ha);
		return {v, 1'b0, x.sign, m};
	endfunction : expect_ref
	// status as word captured, format error, digit error, reverse, full, unit, decimals
	function automatic logic [31:0] stat_exp(input pdref_cfg_t c, input logic [18:0] e);
		logic [1:0] u;
		logic       f;
		u = (c.fmt == FMT_BINARY) ? 2'h2 : (c.fmt == FMT_BCD5) ? 2'h3 : (c.fmt >= FMT_HZ_FIRST) ? 2'h1 : 2'h0;
		f = c.fmt == FMT_BCD5 && (c.board8 || !c.width16);
		return {23'h0, 2'(c.fmt % 3'h3), u, e[17], e[16], !e[18] && !f, f, 1'b1};
	endfunction : stat_exp
	// config register word built from the field positions, not the struct order
	function automatic logic [31:0] cfg_word(input pdref_cfg_t c);
		logic [31:0] v;
		v                    = '0;
		v[CFG_FMT_LSB +: 3]  = c.fmt;
		v[CFG_WIDTH_BIT]     = c.width16;
		v[CFG_BOARD8_BIT]    = c.board8;
		return v;
	endfunction : cfg_word
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic done;
		done = 1'b0;
		rd_q.push_back({m, e});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		@(posedge clk);
	endtask : rd
	task automatic frame(input pdref_word_t x, input logic s);
		last_e = expect_ref(cfg, x);
		ref_q.push_back(last_e);
		word <= x;
		slow <= s;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		do @(posedge clk); while (busy);
		rd(OFF_VALUE, 32'hffff, {16'h0, last_e[15:0]});
		rd(OFF_RAW, 32'h1ffff, {15'h0, x});
		rd(OFF_STATUS, 32'h1ff, stat_exp(cfg, last_e));
	endtask : frame
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		if (loaded) begin
			ref_e = (ref_q.size() > 0) ? ref_q.pop_front() : 19'h7ffff;
			`CHK({valid, full, rev, mag}, ref_e)
		end
		if (rvalid && rready) begin
			rd_e = (rd_q.size() > 0) ? rd_q.pop_front() : '1;
			`CHK({rresp, rdata & rd_e[63:32]}, {RESP_OKAY, rd_e[31:0]})
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFF_CONFIG, 32'h1f, {27'h0, CFG_RESET});
		for (int k = 0; k < 32; k++) begin
			cfg = pdref_cfg_t'(k[4:0]);
			wr(OFF_CONFIG, cfg_word(cfg));
			rd(OFF_CONFIG, 32'h1f, cfg_word(cfg));
			for (int n = 0; n < 3; n++) begin
				rnd = lfsr(rnd);
				w = mkword(cfg, rnd);
				if (n == 2 && cfg.fmt == FMT_BINARY) w = {rnd[5], 16'hffff};
				// one illegal low digit per BCD setting drives the digit error path
				if (n == 1 && cfg.fmt <= FMT_BCD_LAST) w.low[3:0] = 4'hb;
				frame(w, n[0]);
			end
		end
		// read-only value register ignores writes
		wr(OFF_VALUE, 32'h1234);
		rd(OFF_VALUE, 32'hffff, {16'h0, last_e[15:0]});
		end_sim();
	end
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		end_sim();
	end
endmodule : pdref_decoder_bench
`default_nettype wire
